// *** cap_fifo.sv ***
// Small valid/ready FIFO built from flip-flops
`timescale 1ns/10ps
module cap_fifo
  import precomp_pkg::*;
#(
  parameter int WIDTH = CAP_WIDTH,
  parameter int DEPTH = CAP_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  // Whole state of the FIFO
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } fifo_state_t;

  fifo_state_t cur_q;
  fifo_state_t nxt_d;
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count
  assign in_ready = (cur_q.count != DEPTH_CNT);
  assign out_valid = (cur_q.count != '0);
  assign out_data = cur_q.mem[cur_q.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state: write, read and count
  always_comb
  begin
    nxt_d = cur_q;
    if (push)
    begin
      nxt_d.mem[cur_q.wr_ptr] = in_data;
      nxt_d.wr_ptr = (cur_q.wr_ptr == PTR_LAST) ? '0 : cur_q.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      nxt_d.rd_ptr = (cur_q.rd_ptr == PTR_LAST) ? '0 : cur_q.rd_ptr + 1'b1;
    end
    // Simultaneous push and pop leaves the count alone
    if (push && !pop)
    begin
      nxt_d.count = cur_q.count + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_d.count = cur_q.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_q <= '0;
    end
    else
    begin
      cur_q <= nxt_d;
    end
  end

  // Occupancy never passes the depth
  a_fifo_bound: assert property (@(posedge ref_clk) disable iff (rst) cur_q.count <= DEPTH_CNT)
    else $error("fifo count above depth");

endmodule

// *** drive_side_model.sv ***
// Far-side model: double-rate oscillator, drive read data, delay tap and read clock flip-flop
`timescale 1ns/10ps
module drive_side_model #(
  parameter int HALF = 12,   // Double-rate half period, ref_clk cycles
  parameter int RD_HALF = 9  // Read data toggle spacing
)
(
  input wire logic ref_clk,
  input wire logic run,
  input wire logic early_shift_select,
  input wire logic late_shift_select,
  input wire logic data_out,
  output logic double_rate_clock_in,
  output logic read_data_in,
  output logic [1:0] delay_steps,
  output logic read_clock
);
  int cnt = 0;          // Free cycle counter
  logic run_q = 1'b0;   // Registered so the start edge never races the bench
  initial
  begin
    double_rate_clock_in = 1'b0;
    read_data_in = 1'b0;
    read_clock = 1'b0;
  end
  always @(posedge ref_clk) run_q <= run;
  // Pins move off the sampling edge; a stopped oscillator holds its level
  always @(negedge ref_clk)
  begin
    cnt = cnt + 1;
    if (run_q && cnt % HALF == 0) double_rate_clock_in = ~double_rate_clock_in;
    if (cnt % RD_HALF == 0) read_data_in = ~read_data_in;
  end
  // Delay line tap: early shortest, late longest
  assign delay_steps = early_shift_select ? 2'h0 : (late_shift_select ? 2'h2 : 2'h1);
  // External flip-flop halves the selected reference data_out on its falling edge
  always @(negedge data_out) read_clock <= ~read_clock;
endmodule

// *** precomp_pkg.sv ***
// Shared constants and types for the precompensation and separator support block
package precomp_pkg;

  // Positions of the pin inputs inside the synchroniser vectors
  localparam int NUM_IN = 9;
  localparam int IDX_DRC = 0;      // Double-rate clock pin
  localparam int IDX_RD = 1;       // Serial read data from the drive
  localparam int IDX_RG = 2;       // Read gate
  localparam int IDX_WG = 3;       // Write gate
  localparam int IDX_WD = 4;       // Write data
  localparam int IDX_EARLY_N = 5;  // Early request, active low
  localparam int IDX_LATE_N = 6;   // Late request, active low
  localparam int IDX_PEN = 7;      // Precompensation enable
  localparam int IDX_MR = 8;       // Master reset pin

  // Shift-select codes, one-hot as {early, nominal, late}
  localparam logic [2:0] SHIFT_EARLY = 3'h4;
  localparam logic [2:0] SHIFT_NOMINAL = 3'h2;
  localparam logic [2:0] SHIFT_LATE = 3'h1;
  localparam logic [2:0] SHIFT_RST = SHIFT_NOMINAL;

  // Divider figures: a fast floppy half period is five double-rate half periods
  localparam logic [2:0] FAST_HALF_EDGES = 3'h5;
  localparam logic [2:0] FAST_CNT_LAST = FAST_HALF_EDGES - 3'h1;
  localparam logic [2:0] FAST_CNT_RST = 3'h0;
  localparam int NOMINAL_WRITE_CLOCK_KHZ = 5000;  // Nominal write clock with a 10 MHz double-rate input

  // Reset values of the clock outputs and flags
  localparam logic CLK_OUT_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [NUM_IN-1:0] SYNC_RST = 9'h060;  // Request pins idle high

  // Capture buffer shape: {write data bit, shift code}
  localparam int CAP_WIDTH = 4;
  localparam int CAP_DEPTH = 8;

  // Data separator reference selection
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b001,
    MODE_READ = 3'b010,
    MODE_WRITE = 3'b100
  } sep_mode_t;

endpackage

// *** precomp_support.sv ***
// Write precompensation latch, clock dividers and separator reference select
`timescale 1ns/10ps
module precomp_support
  import precomp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic double_rate_clock_in,
  input wire logic read_data_in,
  input wire logic read_gate_in,
  input wire logic write_gate_in,
  input wire logic write_data_in,
  input wire logic early_req_n,
  input wire logic late_req_n,
  input wire logic precomp_enable_in,
  input wire logic master_reset_in,
  output logic early_shift_select,
  output logic nominal_shift_select,
  output logic late_shift_select,
  output logic write_clock_out,
  output logic fast_floppy_clock,
  output logic slow_floppy_clock,
  output logic data_out,
  output logic [2:0] sep_mode,
  output logic capture_accept,
  output logic capture_overrun,
  output logic capture_valid,
  input wire logic capture_take,
  output logic [CAP_WIDTH-1:0] capture_data
);

  // Decode of the request pins into a one-hot shift code
  // Gate and enable tested again so the decode is safe on its own
  function automatic logic [2:0] shift_decode(input logic pen, input logic wg, input logic early_n,
                                              input logic late_n);
    logic early;
    logic late;
    early = !early_n;
    late = !late_n;
    if (!pen || !wg)
    begin
      shift_decode = SHIFT_NOMINAL;
    end
    else if (early && !late)
    begin
      shift_decode = SHIFT_EARLY;
    end
    else if (late && !early)
    begin
      shift_decode = SHIFT_LATE;
    end
    else
    begin
      shift_decode = SHIFT_NOMINAL;  // Both or neither asserted
    end
  endfunction

  // Whole state of the block
  typedef struct packed {
    logic [NUM_IN-1:0] meta;  // First synchroniser stage
    logic [NUM_IN-1:0] sync;  // Second synchroniser stage
    logic drc_prev;           // Delayed double-rate level for edges
    logic wc;                 // Write clock
    logic [2:0] fast_cnt;     // Half-period counter of the fast clock
    logic fast;               // Fast floppy clock
    logic slow;               // Slow floppy clock
    logic [2:0] shift;        // Shift-select latch
    sep_mode_t mode;          // Separator reference mode
    logic dout;               // Selected reference
    logic push;               // Capture request
    logic [CAP_WIDTH-1:0] push_data;
    logic overrun;            // Sticky lost-capture flag
  } state_t;

  state_t cur_q;
  state_t nxt_d;
  logic [NUM_IN-1:0] pins;
  logic drc;
  logic drc_rise;
  logic drc_fall;
  logic mr;
  logic write_ok;
  logic fifo_in_ready;

  // Pin bundle in synchroniser order
  assign pins = {master_reset_in, precomp_enable_in, late_req_n, early_req_n, write_data_in,
                 write_gate_in, read_gate_in, read_data_in, double_rate_clock_in};

  // Edges are seen only after two stages
  // Limitation: each double-rate level must last at least one ref_clk cycle,
  // or the detector misses the edge and the dividers slip
  assign drc = cur_q.sync[IDX_DRC];
  assign drc_rise = drc && !cur_q.drc_prev;
  assign drc_fall = !drc && cur_q.drc_prev;
  assign mr = cur_q.sync[IDX_MR];
  assign write_ok = cur_q.sync[IDX_PEN] && cur_q.sync[IDX_WG];

  // Next-state logic
  always_comb
  begin
    nxt_d = cur_q;
    nxt_d.meta = pins;
    nxt_d.sync = cur_q.meta;
    nxt_d.drc_prev = drc;
    nxt_d.push = 1'b0;

    // Clock generator; master reset holds it cleared
    if (mr)
    begin
      nxt_d.wc = CLK_OUT_RST;
      nxt_d.fast = CLK_OUT_RST;
      nxt_d.slow = CLK_OUT_RST;
      nxt_d.fast_cnt = FAST_CNT_RST;
      nxt_d.overrun = FLAG_RST;
    end
    else
    begin
      // Toggle per rising edge gives a 50 percent halved clock
      if (drc_rise)
      begin
        nxt_d.wc = !cur_q.wc;
      end
      // Counting both edges keeps the odd divider symmetrical
      if (drc_rise || drc_fall)
      begin
        if (cur_q.fast_cnt == FAST_CNT_LAST)
        begin
          nxt_d.fast_cnt = FAST_CNT_RST;
          nxt_d.fast = !cur_q.fast;
          if (cur_q.fast)
          begin
            nxt_d.slow = !cur_q.slow;
          end
        end
        else
        begin
          nxt_d.fast_cnt = cur_q.fast_cnt + 3'h1;
        end
      end
    end

    // Shift latch: nominal at once when precomp or write gate is off, else latched on falling edge
    if (!write_ok)
    begin
      nxt_d.shift = SHIFT_NOMINAL;
    end
    else if (drc_fall)
    begin
      nxt_d.shift = shift_decode(cur_q.sync[IDX_PEN], cur_q.sync[IDX_WG], cur_q.sync[IDX_EARLY_N],
                                 cur_q.sync[IDX_LATE_N]);
      nxt_d.push = 1'b1;
      nxt_d.push_data = {cur_q.sync[IDX_WD], nxt_d.shift};
    end

    // A capture the buffer could not take is remembered until master reset
    if (cur_q.push && !fifo_in_ready)
    begin
      nxt_d.overrun = 1'b1;
    end

    // Write gate wins over read gate
    if (cur_q.sync[IDX_WG])
    begin
      nxt_d.mode = MODE_WRITE;
    end
    else if (cur_q.sync[IDX_RG])
    begin
      nxt_d.mode = MODE_READ;
    end
    else
    begin
      nxt_d.mode = MODE_IDLE;
    end

    // Reference mux driven from the registered mode
    unique case (cur_q.mode)
      MODE_IDLE: nxt_d.dout = drc;
      MODE_READ: nxt_d.dout = cur_q.sync[IDX_RD];
      MODE_WRITE: nxt_d.dout = cur_q.sync[IDX_WD];
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_q.meta <= SYNC_RST;
      cur_q.sync <= SYNC_RST;
      cur_q.drc_prev <= SYNC_RST[IDX_DRC];
      cur_q.wc <= CLK_OUT_RST;
      cur_q.fast_cnt <= FAST_CNT_RST;
      cur_q.fast <= CLK_OUT_RST;
      cur_q.slow <= CLK_OUT_RST;
      cur_q.shift <= SHIFT_RST;
      cur_q.mode <= MODE_IDLE;
      cur_q.dout <= CLK_OUT_RST;
      cur_q.push <= FLAG_RST;
      cur_q.push_data <= '0;
      cur_q.overrun <= FLAG_RST;
    end
    else
    begin
      cur_q <= nxt_d;
    end
  end

  // Outputs from flip-flops except capture_accept, capture_valid and capture_data, which come from the buffer; the delay line outside reads the selects
  assign early_shift_select = cur_q.shift[2];
  assign nominal_shift_select = cur_q.shift[1];
  assign late_shift_select = cur_q.shift[0];
  assign write_clock_out = cur_q.wc;
  assign fast_floppy_clock = cur_q.fast;
  assign slow_floppy_clock = cur_q.slow;
  assign data_out = cur_q.dout;
  assign sep_mode = cur_q.mode;
  assign capture_overrun = cur_q.overrun;
  assign capture_accept = fifo_in_ready;

  // Buffer of latched shift decisions for a downstream consumer
  cap_fifo #(
    .WIDTH(CAP_WIDTH),
    .DEPTH(CAP_DEPTH)
  ) u_cap_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(cur_q.push),
    .in_ready(fifo_in_ready),
    .in_data(cur_q.push_data),
    .out_valid(capture_valid),
    .out_ready(capture_take),
    .out_data(capture_data)
  );

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Shift latch guards
  a_shift_onehot: assert property ($onehot({early_shift_select, nominal_shift_select, late_shift_select}))
    else $error("shift selects not one-hot");
  a_shift_needs_enable: assert property (!nominal_shift_select |-> $past(write_ok))
    else $error("early or late without enable and write gate");
  a_latch_early: assert property (drc_fall && write_ok && !cur_q.sync[IDX_EARLY_N]
    && cur_q.sync[IDX_LATE_N] |=> early_shift_select)
    else $error("early request not latched");
  a_latch_late: assert property (drc_fall && write_ok && cur_q.sync[IDX_EARLY_N]
    && !cur_q.sync[IDX_LATE_N] |=> late_shift_select)
    else $error("late request not latched");
  a_nominal_when_off: assert property (!write_ok |=> nominal_shift_select)
    else $error("select not nominal without enable and write gate");

  // Divider guards
  a_wc_halves: assert property (!mr |=> (write_clock_out != $past(write_clock_out)) == $past(drc_rise))
    else $error("write clock not toggled by rising edge");
  a_fast_divide: assert property ($changed(fast_floppy_clock) && !$past(mr)
    |-> $past(cur_q.fast_cnt == FAST_CNT_LAST && (drc_rise || drc_fall)))
    else $error("fast clock toggled off count");
  a_fast_cnt_range: assert property (cur_q.fast_cnt <= FAST_CNT_LAST)
    else $error("fast divider count out of range");
  a_slow_from_fast: assert property ($changed(slow_floppy_clock) && !$past(mr) |-> $fell(fast_floppy_clock))
    else $error("slow clock not on fast falling edge");
  a_mr_clears: assert property (mr |=> !write_clock_out && !fast_floppy_clock && !slow_floppy_clock)
    else $error("master reset did not clear dividers");

  // Reference select guards
  a_write_mode: assert property (cur_q.sync[IDX_WG] |=> sep_mode == MODE_WRITE
    ##1 data_out == $past(cur_q.sync[IDX_WD]))
    else $error("write data not routed");
  a_read_mode: assert property (cur_q.sync[IDX_RG] && !cur_q.sync[IDX_WG] |=> sep_mode == MODE_READ)
    else $error("read mode not selected");
  a_read_route: assert property (sep_mode == MODE_READ |=> data_out == $past(cur_q.sync[IDX_RD]))
    else $error("read data not routed");
  a_idle_mode: assert property (sep_mode == MODE_IDLE |=> data_out == $past(drc))
    else $error("idle reference not double-rate clock");

  // Lost captures stay flagged until master reset
  a_overrun_sticky: assert property (capture_overrun && !mr |=> capture_overrun)
    else $error("overrun flag dropped without master reset");

  // Main scenarios
  c_write_early: cover property (sep_mode == MODE_WRITE && early_shift_select);
  c_read_mode: cover property (sep_mode == MODE_READ ##1 $changed(data_out));
  c_fifo_full: cover property (!capture_accept);
  c_slow_toggle: cover property ($rose(slow_floppy_clock));
  c_overrun: cover property ($rose(capture_overrun));

endmodule

// *** tb_write_precomp_separator_support.sv ***
// Self-checking testbench for the precompensation and separator support block
`timescale 1ns/10ps
module tb_write_precomp_separator_support;
  import precomp_pkg::*;
  localparam int HALF = 12;  // Double-rate half period in cycles
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic read_gate_in = 1'b0, write_gate_in = 1'b0, write_data_in = 1'b0;
  logic early_req_n = 1'b1, late_req_n = 1'b1, precomp_enable_in = 1'b0;
  logic master_reset_in = 1'b0, capture_take = 1'b1, run = 1'b0;
  logic double_rate_clock_in, read_data_in, data_out;
  logic early_shift_select, nominal_shift_select, late_shift_select;
  logic write_clock_out, fast_floppy_clock, slow_floppy_clock;
  logic capture_accept, capture_overrun, capture_valid;
  logic [2:0] sep_mode;
  logic [2:0] sel;
  logic [CAP_WIDTH-1:0] capture_data;
  int mismatches = 0, num_checks = 0, wc_n = 0, fast_n = 0, slow_n = 0;
  time wc_r, wc_f, fast_r, fast_f, fast_lo, slow_r, slow_f;
  assign sel = {early_shift_select, nominal_shift_select, late_shift_select};

  precomp_support dut (.ref_clk(ref_clk), .rst(rst), .double_rate_clock_in(double_rate_clock_in),
    .read_data_in(read_data_in), .read_gate_in(read_gate_in), .write_gate_in(write_gate_in),
    .write_data_in(write_data_in), .early_req_n(early_req_n), .late_req_n(late_req_n),
    .precomp_enable_in(precomp_enable_in), .master_reset_in(master_reset_in),
    .early_shift_select(early_shift_select), .nominal_shift_select(nominal_shift_select),
    .late_shift_select(late_shift_select), .write_clock_out(write_clock_out),
    .fast_floppy_clock(fast_floppy_clock), .slow_floppy_clock(slow_floppy_clock), .data_out(data_out),
    .sep_mode(sep_mode), .capture_accept(capture_accept), .capture_overrun(capture_overrun),
    .capture_valid(capture_valid), .capture_take(capture_take), .capture_data(capture_data));
  drive_side_model #(.HALF(HALF), .RD_HALF(9)) far (.ref_clk(ref_clk), .run(run),
    .early_shift_select(early_shift_select), .late_shift_select(late_shift_select), .data_out(data_out),
    .double_rate_clock_in(double_rate_clock_in), .read_data_in(read_data_in), .delay_steps(), .read_clock());

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end
  // Rise counts and edge times of the divided clocks
  always @(posedge write_clock_out) wc_n++;
  always @(posedge fast_floppy_clock) fast_n++;
  always @(posedge slow_floppy_clock) slow_n++;
  always @(posedge write_clock_out) wc_r = $time;
  always @(negedge write_clock_out) wc_f = $time;
  always @(posedge fast_floppy_clock) fast_r = $time;
  always @(posedge fast_floppy_clock) fast_lo <= $time - fast_f;
  always @(negedge fast_floppy_clock) fast_f = $time;
  always @(posedge slow_floppy_clock) slow_r = $time;
  always @(negedge slow_floppy_clock) slow_f = $time;

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic chk3(input logic [2:0] got, input logic [2:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s: got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Values held while reset is asserted
  task automatic t_reset();
    chk3(sel, SHIFT_NOMINAL, "select in reset");
    chk3(sep_mode, MODE_IDLE, "mode in reset");
    chk3({write_clock_out, fast_floppy_clock, slow_floppy_clock}, 3'h0, "clocks in reset");
    chk1(capture_valid, 1'b0, "fifo empty in reset");
    chk1(capture_accept, 1'b1, "fifo accepts in reset");
  endtask
  // Exactly 80 double-rate edges after a master reset, then reset mid-run
  task automatic t_clocks();
    master_reset_in = 1'b1;
    tick(6);
    master_reset_in = 1'b0;
    tick(6);
    wc_n = 0;
    fast_n = 0;
    slow_n = 0;
    run = 1'b1;
    tick(80 * HALF);
    run = 1'b0;
    tick(8);
    chkn(wc_n, 20, "write clock rises");
    chkn(fast_n, 8, "fast clock rises");
    chkn(slow_n, 4, "slow clock rises");
    chkn(int'(wc_f - wc_r), 8 * HALF, "write clock high ns");
    chkn(int'(fast_f - fast_r), 20 * HALF, "fast clock high ns");
    chkn(int'(fast_lo), 20 * HALF, "fast clock low ns");
    chkn(int'(slow_f - slow_r), 40 * HALF, "slow clock high ns");
    run = 1'b1;
    tick(100);
    master_reset_in = 1'b1;
    tick(40);
    chk3({write_clock_out, fast_floppy_clock, slow_floppy_clock}, 3'h0, "clocks held");
    master_reset_in = 1'b0;
  endtask
  // Every gate combination, each source seen in both levels
  task automatic t_modes();
    logic [2:0] exp;
    for (int i = 0; i < 4; i++)
    begin
      {read_gate_in, write_gate_in} = i[1:0];
      exp = i[0] ? MODE_WRITE : (i[1] ? MODE_READ : MODE_IDLE);
      repeat (2)
      begin
        write_data_in = ~write_data_in;
        if (!i[0] && i[1]) @(read_data_in);
        else if (!i[0]) @(double_rate_clock_in);
        tick(5);
        chk1(data_out, i[0] ? write_data_in : (i[1] ? read_data_in : double_rate_clock_in), "source");
      end
      chk3(sep_mode, exp, "mode");
    end
    {read_gate_in, write_gate_in} = 2'h0;
  endtask
  // Requests change on a rising edge; latch must wait for the fall
  task automatic t_shift();
    logic [2:0] prev;
    logic [2:0] exp;
    prev = SHIFT_NOMINAL;
    write_gate_in = 1'b1;
    precomp_enable_in = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      exp = (i == 1) ? SHIFT_EARLY : ((i == 2) ? SHIFT_LATE : SHIFT_NOMINAL);
      @(posedge double_rate_clock_in);
      {early_req_n, late_req_n} = i[1:0];
      tick(5);
      chk3(sel, prev, "select before fall");
      @(negedge double_rate_clock_in);
      tick(5);
      chk3(sel, exp, "select after fall");
      prev = exp;
    end
    {early_req_n, late_req_n} = 2'h1;
    @(negedge double_rate_clock_in);
    tick(5);
    chk3(sel, SHIFT_EARLY, "select before enable drop");
    precomp_enable_in = 1'b0;
    tick(5);
    chk3(sel, SHIFT_NOMINAL, "select enable low");
    precomp_enable_in = 1'b1;
    write_gate_in = 1'b0;
    @(negedge double_rate_clock_in);
    tick(5);
    chk3(sel, SHIFT_NOMINAL, "select outside write");
  endtask
  // Overfill with consumer stalled, then drain to empty
  task automatic t_fifo();
    int n;
    n = 0;
    capture_take = 1'b0;
    write_data_in = 1'b1;
    write_gate_in = 1'b1;
    repeat (10) @(negedge double_rate_clock_in);
    tick(5);
    chk1(capture_accept, 1'b0, "fifo full");
    chk1(capture_overrun, 1'b1, "overrun flag");
    chk3(sel, SHIFT_EARLY, "select while full");
    precomp_enable_in = 1'b0;
    tick(5);
    capture_take = 1'b1;
    while (capture_valid === 1'b1 && n < 20)
    begin
      chk3(capture_data[2:0], SHIFT_EARLY, "fifo code");
      chk1(capture_data[3], 1'b1, "fifo write bit");
      n++;
      tick(1);
    end
    chkn(n, CAP_DEPTH, "words drained");
    chk1(capture_accept, 1'b1, "fifo empty accepts");
    master_reset_in = 1'b1;
    tick(4);
    chk1(capture_overrun, 1'b0, "overrun cleared");
    master_reset_in = 1'b0;
    write_gate_in = 1'b0;
  endtask

  initial
  begin
    tick(2);
    t_reset();
    rst = 1'b0;
    tick(2);
    t_clocks();
    t_modes();
    t_shift();
    t_fifo();
    conclude();
  end
  // Run needs about 1700 cycles; cut a hang well beyond that
  initial
  begin
    #100000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule
